// file: design/fifo_host_pkg.sv
// Constants, the device pin bundle and state encodings for the FIFO host controller.
package fifo_host_pkg;

	localparam int DATA_W   = 9;
	localparam int DEPTH    = 512;
	localparam int CLK_PS   = 5000;
	localparam int SYNC_CYC = 2;

	// ==================================================================
	// Register map
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] CFG_OFS    = 8'h04;
	localparam logic [7:0] WDATA_OFS  = 8'h08;
	localparam logic [7:0] RDATA_OFS  = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;

	localparam int CTRL_READ_BIT   = 0;
	localparam int CTRL_WRITE_BIT  = 1;
	localparam int CTRL_CLEAR_BIT  = 2;
	localparam int CTRL_REREAD_BIT = 3;
	localparam int CTRL_ACK_BIT    = 4;
	localparam int CFG_CHAIN_BIT   = 0;
	localparam int CFG_FIRST_BIT   = 1;

	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_EMPTY_BIT   = 1;
	localparam int ST_FULL_BIT    = 2;
	localparam int ST_RVALID_BIT  = 3;
	localparam int ST_REFUSED_BIT = 4;
	localparam int ST_CHAIN_BIT   = 5;
	localparam int ST_FVALID_BIT  = 6;

	localparam logic [1:0] CFG_RESET = 2'h0;

	// ==================================================================
	// Device timing in ns, fastest grade, and derived cycle counts
	localparam int PULSE_NS        = 65;
	localparam int ACCESS_NS       = 65;
	localparam int RECOVERY_NS     = 15;
	localparam int CLEAR_SETUP_NS  = 45;
	localparam int CYCLE_TIME_NS   = 80;
	localparam int DATA_SETUP_NS   = 20;
	localparam int DATA_HOLD_NS    = 10;
	localparam int FLAG_TO_OP_NS   = 10;

	function automatic int ns_up(input int ns);
		return (ns * 1000 + CLK_PS - 1) / CLK_PS;
	endfunction

	function automatic int imax(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	localparam int PULSE_CYC   = ns_up(PULSE_NS);
	localparam int RD_LOW_CYC  = imax(PULSE_CYC, ns_up(ACCESS_NS)) + SYNC_CYC;
	localparam int WR_LOW_CYC  = imax(PULSE_CYC, ns_up(DATA_SETUP_NS));
	localparam int HOLD_CYC    = imax(ns_up(DATA_HOLD_NS), ns_up(RECOVERY_NS));
	localparam int REC_CYC     = ns_up(RECOVERY_NS);
	localparam int CTL_LOW_CYC = imax(PULSE_CYC, ns_up(CLEAR_SETUP_NS));
	localparam int SETTLE_CYC  = ns_up(CYCLE_TIME_NS) + SYNC_CYC;
	localparam int FLAG_OK_CYC = ns_up(FLAG_TO_OP_NS);

	// ==================================================================
	// Pin bundle and controller state encoding
	typedef struct packed {
		logic              read_n;
		logic              write_n;
		logic              pointer_clear_in;
		logic              first_or_reread_pin;
		logic              chain_enable_in;
		logic              chain_enable_oe;
		logic [DATA_W-1:0] data_out;
	} dev_out_s;

	typedef enum logic [3:0] {
		S_IDLE,
		S_RD_LOW,
		S_RD_REC,
		S_WR_LOW,
		S_WR_HOLD,
		S_CLR_LOW,
		S_CLR_REC,
		S_RT_LOW,
		S_RT_REC,
		S_SETTLE
	} ctrl_state_e;

endpackage

// file: design/fifo_host_ctrl.sv
// APB-controlled host that drives a 512 x 9 asynchronous FIFO through its pins.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
// ======================================================================
module fifo_host_ctrl #(
	parameter int N_DEV = 1
) (
	input  wire logic                                pclk,         // APB clock
	input  wire logic                                presetn,      // Async reset
	input  wire logic                                psel,         // Slave select
	input  wire logic                                penable,      // Access phase
	input  wire logic                                pwrite,       // Write access
	input  wire logic [7:0]                          paddr,        // Byte address
	input  wire logic [31:0]                         pwdata,       // Write data
	output logic      [31:0]                         prdata,       // Read data
	output logic                                     pready,       // Transfer done
	output logic                                     pslverr,      // Unmapped address
	output fifo_host_pkg::dev_out_s                  dev_o,        // Device pins out
	input  wire logic [N_DEV-1:0]                    empty_flag,   // Empty, low active
	input  wire logic [N_DEV-1:0]                    full_flag,    // Full, low active
	input  wire logic [fifo_host_pkg::DATA_W-1:0]    data_in       // Device outputs
);

	typedef struct packed {
		fifo_host_pkg::ctrl_state_e           state;
		logic [7:0]                           cnt;
		logic [N_DEV-1:0]                     ef_s1;
		logic [N_DEV-1:0]                     ef_s2;
		logic [N_DEV-1:0]                     ff_s1;
		logic [N_DEV-1:0]                     ff_s2;
		logic [fifo_host_pkg::DATA_W-1:0]     q_s1;
		logic [fifo_host_pkg::DATA_W-1:0]     q_s2;
		logic [1:0]                           ef_ok;
		logic [1:0]                           ff_ok;
		logic                                 flags_valid;
		logic                                 empty_seen;
		logic                                 full_seen;
		logic                                 rvalid;
		logic                                 refused;
		logic [1:0]                           cfg;
		logic                                 chain_mode;
		logic [fifo_host_pkg::DATA_W-1:0]     rdata;
		logic [fifo_host_pkg::DATA_W-1:0]     wdata;
		fifo_host_pkg::dev_out_s              pins;
		logic                                 pready;
		logic                                 pslverr;
		logic [31:0]                          prdata;
	} st_s;

	st_s st_r;
	st_s st_nxt;

	// Composite flag: low only when every chained device asserts it.
	function automatic logic merge_flag(input logic [N_DEV-1:0] f, input logic chain);
		return chain ? (|f) : f[0];
	endfunction

	function automatic logic [7:0] lim(input int c);
		return 8'(c - 1);
	endfunction

	logic       ef_comp;
	logic       ff_comp;
	logic       apb_do;
	logic       apb_wr;
	logic       apb_rd;
	logic       mapped;
	logic       cmd_rd;
	logic       cmd_wr;
	logic       cmd_clr;
	logic       cmd_rt;
	logic       busy;
	logic [1:0] ok_max;

	assign ok_max  = 2'(fifo_host_pkg::FLAG_OK_CYC);
	assign ef_comp = merge_flag(st_r.ef_s2, st_r.chain_mode);
	assign ff_comp = merge_flag(st_r.ff_s2, st_r.chain_mode);
	assign busy    = (st_r.state != fifo_host_pkg::S_IDLE);
	assign apb_do  = psel && penable && st_r.pready;
	assign apb_wr  = apb_do && pwrite && !st_r.pslverr;
	assign apb_rd  = apb_do && !pwrite && !st_r.pslverr;
	assign mapped  = (paddr == fifo_host_pkg::CTRL_OFS) || (paddr == fifo_host_pkg::CFG_OFS)
		|| (paddr == fifo_host_pkg::WDATA_OFS) || (paddr == fifo_host_pkg::RDATA_OFS)
		|| (paddr == fifo_host_pkg::STATUS_OFS);
	assign cmd_rd  = apb_wr && (paddr == fifo_host_pkg::CTRL_OFS)
		&& pwdata[fifo_host_pkg::CTRL_READ_BIT];
	assign cmd_wr  = apb_wr && (paddr == fifo_host_pkg::CTRL_OFS)
		&& pwdata[fifo_host_pkg::CTRL_WRITE_BIT];
	assign cmd_clr = apb_wr && (paddr == fifo_host_pkg::CTRL_OFS)
		&& pwdata[fifo_host_pkg::CTRL_CLEAR_BIT];
	assign cmd_rt  = apb_wr && (paddr == fifo_host_pkg::CTRL_OFS)
		&& pwdata[fifo_host_pkg::CTRL_REREAD_BIT];

	// ==================================================================
	// Next state
	always_comb
	begin
		logic step;
		logic refuse;
		step   = 1'b0;
		refuse = 1'b0;
		st_nxt = st_r;

		st_nxt.ef_s1 = empty_flag;
		st_nxt.ef_s2 = st_r.ef_s1;
		st_nxt.ff_s1 = full_flag;
		st_nxt.ff_s2 = st_r.ff_s1;
		st_nxt.q_s1  = data_in;
		st_nxt.q_s2  = st_r.q_s1;

		// Released flag must be stable before a new strobe is issued.
		st_nxt.ef_ok = !ef_comp ? 2'h0 : (st_r.ef_ok == ok_max) ? ok_max : st_r.ef_ok + 2'h1;
		st_nxt.ff_ok = !ff_comp ? 2'h0 : (st_r.ff_ok == ok_max) ? ok_max : st_r.ff_ok + 2'h1;
		if (st_r.flags_valid)
		begin
			st_nxt.empty_seen = ef_comp;
			st_nxt.full_seen  = ff_comp;
		end

		// APB slave: answer one cycle into the access phase.
		st_nxt.pready  = psel && penable && !st_r.pready;
		st_nxt.pslverr = psel && penable && !st_r.pready && !mapped;
		if (psel && penable && !st_r.pready)
		begin
			case (paddr)
				fifo_host_pkg::CFG_OFS:    st_nxt.prdata = {30'h0000_0000, st_r.cfg};
				fifo_host_pkg::WDATA_OFS:  st_nxt.prdata = {23'h00_0000, st_r.wdata};
				fifo_host_pkg::RDATA_OFS:  st_nxt.prdata = {23'h00_0000, st_r.rdata};
				fifo_host_pkg::STATUS_OFS: st_nxt.prdata = {25'h000_0000, st_r.flags_valid,
					st_r.chain_mode, st_r.refused, st_r.rvalid, st_r.full_seen,
					st_r.empty_seen, busy};
				default:                   st_nxt.prdata = 32'h0000_0000;
			endcase
		end
		if (apb_wr && paddr == fifo_host_pkg::CFG_OFS)
			st_nxt.cfg = pwdata[1:0];
		if (apb_wr && paddr == fifo_host_pkg::WDATA_OFS && !busy)
			st_nxt.wdata = pwdata[fifo_host_pkg::DATA_W-1:0];
		if (apb_rd && paddr == fifo_host_pkg::RDATA_OFS)
			st_nxt.rvalid = 1'b0;
		if (apb_wr && paddr == fifo_host_pkg::CTRL_OFS && pwdata[fifo_host_pkg::CTRL_ACK_BIT])
			st_nxt.refused = 1'b0;

		st_nxt.cnt = st_r.cnt + 8'h01;
		case (st_r.state)
			fifo_host_pkg::S_IDLE:
			begin
				st_nxt.cnt = 8'h00;
				if (cmd_clr)
				begin
					st_nxt.state                 = fifo_host_pkg::S_CLR_LOW;
					st_nxt.pins.pointer_clear_in = 1'b0;
					st_nxt.flags_valid           = 1'b0;
				end
				else if (cmd_rt)
				begin
					if (st_r.chain_mode)
						refuse = 1'b1;
					else
					begin
						st_nxt.state                    = fifo_host_pkg::S_RT_LOW;
						st_nxt.pins.first_or_reread_pin = 1'b0;
						st_nxt.flags_valid              = 1'b0;
					end
				end
				else if (cmd_rd)
				begin
					if (st_r.flags_valid && ef_comp && st_r.ef_ok == ok_max)
					begin
						st_nxt.state        = fifo_host_pkg::S_RD_LOW;
						st_nxt.pins.read_n  = 1'b0;
					end
					else
						refuse = 1'b1;
				end
				else if (cmd_wr)
				begin
					if (st_r.flags_valid && ff_comp && st_r.ff_ok == ok_max)
					begin
						st_nxt.state        = fifo_host_pkg::S_WR_LOW;
						st_nxt.pins.write_n = 1'b0;
					end
					else
						refuse = 1'b1;
				end
			end
			fifo_host_pkg::S_RD_LOW:
			begin
				if (st_r.cnt == lim(fifo_host_pkg::RD_LOW_CYC))
				begin
					st_nxt.rdata       = st_r.q_s2;
					st_nxt.rvalid      = 1'b1;
					st_nxt.pins.read_n = 1'b1;
					st_nxt.state       = fifo_host_pkg::S_RD_REC;
					step               = 1'b1;
				end
			end
			fifo_host_pkg::S_RD_REC:
			begin
				// Covers output float time and lets the empty flag resettle.
				if (st_r.cnt == lim(fifo_host_pkg::REC_CYC + fifo_host_pkg::SYNC_CYC))
				begin
					st_nxt.state = fifo_host_pkg::S_IDLE;
					step         = 1'b1;
				end
			end
			fifo_host_pkg::S_WR_LOW:
			begin
				if (st_r.cnt == lim(fifo_host_pkg::WR_LOW_CYC))
				begin
					st_nxt.pins.write_n = 1'b1;
					st_nxt.state        = fifo_host_pkg::S_WR_HOLD;
					step                = 1'b1;
				end
			end
			fifo_host_pkg::S_WR_HOLD:
			begin
				if (st_r.cnt == lim(fifo_host_pkg::HOLD_CYC + fifo_host_pkg::SYNC_CYC))
				begin
					st_nxt.state = fifo_host_pkg::S_IDLE;
					step         = 1'b1;
				end
			end
			fifo_host_pkg::S_CLR_LOW:
			begin
				// Strobes stay high through the whole clear pulse.
				if (st_r.cnt == lim(fifo_host_pkg::CTL_LOW_CYC))
				begin
					st_nxt.pins.pointer_clear_in    = 1'b1;
					st_nxt.chain_mode               = st_r.cfg[fifo_host_pkg::CFG_CHAIN_BIT];
					st_nxt.state                    = fifo_host_pkg::S_CLR_REC;
					step                            = 1'b1;
				end
				st_nxt.pins.chain_enable_oe     = !st_r.cfg[fifo_host_pkg::CFG_CHAIN_BIT];
				st_nxt.pins.first_or_reread_pin = !(st_r.cfg[fifo_host_pkg::CFG_CHAIN_BIT]
					&& st_r.cfg[fifo_host_pkg::CFG_FIRST_BIT]);
			end
			fifo_host_pkg::S_CLR_REC, fifo_host_pkg::S_RT_REC:
			begin
				if (st_r.cnt == lim(fifo_host_pkg::REC_CYC))
				begin
					st_nxt.state = fifo_host_pkg::S_SETTLE;
					step         = 1'b1;
				end
			end
			fifo_host_pkg::S_RT_LOW:
			begin
				if (st_r.cnt == lim(fifo_host_pkg::CTL_LOW_CYC))
				begin
					st_nxt.pins.first_or_reread_pin = 1'b1;
					st_nxt.state                    = fifo_host_pkg::S_RT_REC;
					step                            = 1'b1;
				end
			end
			fifo_host_pkg::S_SETTLE:
			begin
				if (st_r.cnt == lim(fifo_host_pkg::SETTLE_CYC))
				begin
					st_nxt.flags_valid = 1'b1;
					st_nxt.state       = fifo_host_pkg::S_IDLE;
					step               = 1'b1;
				end
			end
			default:
			begin
				st_nxt.state = fifo_host_pkg::S_IDLE;
				step         = 1'b1;
			end
		endcase
		if (step)
			st_nxt.cnt = 8'h00;
		// Commands that arrive while busy are dropped and flagged.
		if (busy && (cmd_rd || cmd_wr || cmd_clr || cmd_rt))
			refuse = 1'b1;
		if (refuse)
			st_nxt.refused = 1'b1;
		st_nxt.pins.data_out = st_r.wdata;
	end

	// ==================================================================
	// State register; power-up runs a clear pulse before anything else.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r                          <= '0;
			st_r.state                    <= fifo_host_pkg::S_CLR_LOW;
			st_r.cfg                      <= fifo_host_pkg::CFG_RESET;
			st_r.pins.read_n              <= 1'b1;
			st_r.pins.write_n             <= 1'b1;
			st_r.pins.pointer_clear_in    <= 1'b0;
			st_r.pins.first_or_reread_pin <= 1'b1;
			st_r.pins.chain_enable_in     <= 1'b0;
			st_r.pins.chain_enable_oe     <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign dev_o   = st_r.pins;
	assign prdata  = st_r.prdata;
	assign pready  = st_r.pready;
	assign pslverr = st_r.pslverr;

endmodule

// file: tb/fifo_dev_model.sv
// Behavioural 512 x 9 asynchronous FIFO device, driven only by its pins.
`timescale 1ns/1ps
module fifo_dev_model #(
	parameter int ACC_NS  = 20, // Read access delay
	parameter int FLAG_NS = 30  // Flag update delay
) (
	input  wire logic       read_n,              // Read strobe
	input  wire logic       write_n,             // Write strobe
	input  wire logic       pointer_clear_in,    // Pointer clear
	input  wire logic       first_or_reread_pin, // Reread pulse
	input  wire logic       chain_enable_in,     // Chain input
	input  wire logic [8:0] data_d,              // Data in
	output logic      [8:0] data_q,              // Data out
	output logic            empty_flag,          // Empty, low active
	output logic            full_flag,           // Full, low active
	output logic            chain_token_out      // Token to next device
);
	logic [8:0] mem [0:511];
	int         rd;
	int         wr;
	int         cnt;
	bit         cleared;
	bit         wr_ok;
	bit         standalone;
	bit         wr_en;

	task automatic flags_upd;
		empty_flag <= #(FLAG_NS) (cnt != 0);
		full_flag <= #(FLAG_NS) (cnt != 512);
	endtask

	task automatic token_pulse;
		chain_token_out = 1'b0;
		chain_token_out <= #(FLAG_NS) 1'b1;
	endtask

	initial
	begin
		data_q = 9'h000;
		empty_flag = 1'b0;
		full_flag = 1'b1;
		chain_token_out = 1'b1;
	end

	always @(pointer_clear_in)
		if (!pointer_clear_in)
		begin
			rd = 0;
			wr = 0;
			cnt = 0;
			cleared = 1'b1;
			flags_upd();
		end

	// The mode is taken as the clear pin is released, once the mode pins have settled.
	always @(posedge pointer_clear_in)
	begin
		standalone = !chain_enable_in;
		wr_en = standalone || !first_or_reread_pin;
	end

	always @(negedge chain_enable_in)
		if (pointer_clear_in)
			wr_en = 1'b1;

	always @(negedge read_n)
		if (empty_flag && pointer_clear_in)
		begin
			data_q <= #(ACC_NS) mem[rd];
			if (rd == 511)
				token_pulse();
			rd = (rd + 1) % 512;
			cnt--;
			flags_upd();
		end

	// A released bus shows the inverse of its last value, never a held copy.
	always @(posedge read_n)
		data_q = ~data_q;

	always @(negedge write_n)
		wr_ok = full_flag && cleared && wr_en;

	always @(posedge write_n)
		if (wr_ok)
		begin
			mem[wr] = data_d;
			if (wr == 511)
				token_pulse();
			wr = (wr + 1) % 512;
			cnt++;
			flags_upd();
		end

	always @(negedge first_or_reread_pin)
		if (standalone && pointer_clear_in)
		begin
			rd = 0;
			cnt = wr;
			flags_upd();
		end
endmodule

// file: tb/fifo_host_assertions.sv
// Port-level checker for the FIFO host controller.
`timescale 1ns/1ps
module fifo_host_assertions #(
	parameter int N_DEV = 1
) (
	input wire logic                             pclk,       // Clock
	input wire logic                             presetn,    // Reset
	input wire logic                             psel,       // Select
	input wire logic                             penable,    // Access
	input wire logic                             pwrite,     // Direction
	input wire logic [7:0]                       paddr,      // Address
	input wire logic [31:0]                      pwdata,     // Write data
	input wire logic [31:0]                      prdata,     // Read data
	input wire logic                             pready,     // Ready
	input wire logic                             pslverr,    // Error
	input wire fifo_host_pkg::dev_out_s          dev_o,      // Device pins
	input wire logic [N_DEV-1:0]                 empty_flag, // Empty
	input wire logic [N_DEV-1:0]                 full_flag,  // Full
	input wire logic [fifo_host_pkg::DATA_W-1:0] data_in     // Device data
);
	logic [5:0] idle_cnt;
	logic [5:0] rd_cnt;
	logic [5:0] wr_cnt;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			idle_cnt <= 6'h00;
			rd_cnt <= 6'h00;
			wr_cnt <= 6'h00;
		end
		else
		begin
			idle_cnt <= (dev_o.read_n && dev_o.write_n) ?
				((idle_cnt == 6'h3F) ? idle_cnt : idle_cnt + 6'h01) : 6'h00;
			rd_cnt <= dev_o.read_n ? 6'h00 : rd_cnt + 6'h01;
			wr_cnt <= dev_o.write_n ? 6'h00 : wr_cnt + 6'h01;
		end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_ready_once;
		pready |=> !pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("pready longer than one cycle");
	property p_answer;
		psel && penable && !pready |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("pready late");
	property p_slverr;
		pready |-> (pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}));
	endproperty
	a_slverr: assert property (p_slverr) else $error("pslverr wrong for address");
	property p_read_gate;
		$fell(dev_o.read_n) |-> $past(empty_flag[0], 3);
	endproperty
	a_read_gate: assert property (p_read_gate) else $error("read strobed while empty");
	property p_read_width;
		$rose(dev_o.read_n) |-> rd_cnt == 6'(fifo_host_pkg::RD_LOW_CYC);
	endproperty
	a_read_width: assert property (p_read_width) else $error("read pulse width");
	property p_write_width;
		$rose(dev_o.write_n) |-> wr_cnt == 6'(fifo_host_pkg::WR_LOW_CYC);
	endproperty
	a_write_width: assert property (p_write_width) else $error("write pulse width");
	property p_clear_setup;
		$rose(dev_o.pointer_clear_in) |-> idle_cnt >= 6'h09;
	endproperty
	a_clear_setup: assert property (p_clear_setup) else $error("clear setup short");
	property p_clear_rec;
		$rose(dev_o.pointer_clear_in) |-> (dev_o.read_n && dev_o.write_n) [*4];
	endproperty
	a_clear_rec: assert property (p_clear_rec) else $error("clear recovery short");
	property p_reread_time;
		$rose(dev_o.first_or_reread_pin) && dev_o.chain_enable_oe
			|-> (idle_cnt >= 6'h09) ##1 dev_o.read_n [*3];
	endproperty
	a_reread_time: assert property (p_reread_time) else $error("reread setup");
	property p_standalone;
		dev_o.chain_enable_oe |-> !dev_o.chain_enable_in;
	endproperty
	a_standalone: assert property (p_standalone) else $error("chain input not grounded");
	property p_no_chain_reread;
		$fell(dev_o.first_or_reread_pin) && dev_o.pointer_clear_in |-> dev_o.chain_enable_oe;
	endproperty
	a_no_chain_reread: assert property (p_no_chain_reread) else $error("reread in chain");

	c_read: cover property ($fell(dev_o.read_n));
	c_write: cover property ($fell(dev_o.write_n));
	c_reread: cover property ($fell(dev_o.first_or_reread_pin));
	c_error: cover property (pready && pslverr);
endmodule

bind fifo_host_ctrl fifo_host_assertions #(.N_DEV(N_DEV)) chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_o(dev_o),
	.empty_flag(empty_flag), .full_flag(full_flag), .data_in(data_in));

// file: tb/async_fifo_read_reset_expansion_tb.sv
// Self-checking bench for the FIFO host controller with a device model.
`timescale 1ns/1ps
module async_fifo_read_reset_expansion_tb;
	logic                    pclk;
	logic                    presetn;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [7:0]              paddr;
	logic [31:0]             pwdata;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	fifo_host_pkg::dev_out_s dev_o;
	logic [0:0]              empty_flag;
	logic [0:0]              full_flag;
	logic [8:0]              data_in;
	logic                    chain_pin;
	logic [31:0]             q;
	logic                    e;
	int                      err_count;
	int                      checks;
	int                      cyc;
	int                      rd_falls;

	fifo_host_ctrl #(.N_DEV(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dev_o(dev_o), .empty_flag(empty_flag),
		.full_flag(full_flag), .data_in(data_in));

	// A released chain input floats high through its pull-up.
	assign chain_pin = dev_o.chain_enable_oe ? dev_o.chain_enable_in : 1'b1;

	fifo_dev_model dev (.read_n(dev_o.read_n), .write_n(dev_o.write_n),
		.pointer_clear_in(dev_o.pointer_clear_in), .first_or_reread_pin(dev_o.first_or_reread_pin),
		.chain_enable_in(chain_pin), .data_d(dev_o.data_out), .data_q(data_in),
		.empty_flag(empty_flag[0]), .full_flag(full_flag[0]), .chain_token_out());

	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	always @(negedge dev_o.read_n)
		rd_falls++;

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_count++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x)
		begin
			$display("[ERR] %s expected %h seen %h", n, x, g);
			err_count++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		do
		begin
			apb(1'b0, fifo_host_pkg::STATUS_OFS, 32'h0000_0000);
			n++;
		end
		while (q[0] !== 1'b0 && n < 200);
		chk("busy", 32'h0000_0000, {31'h0, q[0]});
	endtask

	task automatic op(input logic [31:0] c);
		apb(1'b1, fifo_host_pkg::CTRL_OFS, c);
		wait_idle();
	endtask

	task automatic put(input logic [8:0] w);
		apb(1'b1, fifo_host_pkg::WDATA_OFS, {23'h0, w});
		op(32'h0000_0002);
	endtask

	task automatic get(input logic [8:0] x);
		op(32'h0000_0001);
		apb(1'b0, fifo_host_pkg::RDATA_OFS, 32'h0000_0000);
		chk("rdata", {23'h0, x}, q);
	endtask

	task automatic stat(input logic [31:0] x);
		apb(1'b0, fifo_host_pkg::STATUS_OFS, 32'h0000_0000);
		chk("status", x, q);
	endtask

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wait_idle();
		stat(32'h0000_0044);
		$display("test reset done");
		op(32'h0000_0001);
		stat(32'h0000_0054);
		chk("read strobes", 32'h0000_0000, rd_falls);
		op(32'h0000_0010);
		stat(32'h0000_0044);
		$display("test empty read done");
		put(9'h1A5);
		put(9'h05A);
		put(9'h100);
		stat(32'h0000_0046);
		get(9'h1A5);
		get(9'h05A);
		get(9'h100);
		stat(32'h0000_0044);
		$display("test order done");
		op(32'h0000_0008);
		stat(32'h0000_0046);
		put(9'h0F0);
		get(9'h1A5);
		get(9'h05A);
		get(9'h100);
		get(9'h0F0);
		$display("test reread done");
		put(9'h033);
		op(32'h0000_0004);
		stat(32'h0000_0044);
		put(9'h077);
		get(9'h077);
		$display("test clear done");
		apb(1'b1, fifo_host_pkg::CFG_OFS, 32'h0000_0003);
		apb(1'b0, fifo_host_pkg::CFG_OFS, 32'h0000_0000);
		chk("cfg", 32'h0000_0003, q);
		apb(1'b1, fifo_host_pkg::CFG_OFS, 32'h0000_0000);
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, {31'h0, e});
		chk("unmapped", 32'h0000_0000, q);
		apb(1'b0, fifo_host_pkg::CTRL_OFS, 32'h0000_0000);
		chk("ctrl", 32'h0000_0000, q);
		$display("test registers done");
		apb(1'b1, fifo_host_pkg::CFG_OFS, 32'h0000_0001);
		op(32'h0000_0004);
		stat(32'h0000_0064);
		chk("chain oe", 32'h0000_0000, {31'h0, dev_o.chain_enable_oe});
		chk("first pin", 32'h0000_0001, {31'h0, dev_o.first_or_reread_pin});
		put(9'h055);
		stat(32'h0000_0064);
		op(32'h0000_0008);
		stat(32'h0000_0074);
		op(32'h0000_0010);
		apb(1'b1, fifo_host_pkg::CFG_OFS, 32'h0000_0000);
		op(32'h0000_0004);
		stat(32'h0000_0044);
		chk("chain oe", 32'h0000_0001, {31'h0, dev_o.chain_enable_oe});
		$display("test chain done");
		print_verdict();
	end
endmodule
